/* File: tb/pll_clock_synth_control_bench.sv */
// Self-checking bench of the clock synthesizer control block.
// Assumes the design files and constants header are compiled first.
`timescale 1ns/1ps
module pll_clock_synth_control_bench;
  // Design ports
  logic       i_clk, i_sys_rst, i_io_wr, i_io_rd;
  logic [1:0] i_io_sel;
  logic [7:0] i_io_wdata, o_io_rdata;
  logic       o_io_rvalid, i_mem_clk_in, i_dot_clk_in;
  logic       i_video_clock_dir_strap;
  logic [4:0] o_mclk_n;
  logic [1:0] o_mclk_r, o_dot_r, o_dot_src;
  logic [6:0] o_mclk_m;
  logic [5:0] o_dot_n;
  logic [7:0] o_dot_m;
  logic       o_mclk_load, o_mclk_pd, o_dot_load, o_dot_pd;
  logic       o_video_pin_clock_oe, o_two_mclk_writes;
  // Bench state and register model
  int          n_mismatch, checks_done;
  logic [31:0] seed;
  logic [7:0]  regs [256];
  logic [1:0]  misc_sel;
  logic [7:0]  hi, lo, rv;
  logic [7:0]  idx_list [11] = '{8'h08, 8'h10, 8'h11, 8'h12, 8'h13,
    8'h22, 8'h23, 8'h24, 8'h25, 8'h0A, 8'h30};

  pll_clock_synth_control #(.CNT_W(16)) u_pll_clock_synth_control (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_io_wr(i_io_wr),
    .i_io_rd(i_io_rd), .i_io_sel(i_io_sel), .i_io_wdata(i_io_wdata),
    .o_io_rdata(o_io_rdata), .o_io_rvalid(o_io_rvalid),
    .i_mem_clk_in(i_mem_clk_in), .i_dot_clk_in(i_dot_clk_in),
    .i_video_clock_dir_strap(i_video_clock_dir_strap),
    .o_mclk_n(o_mclk_n), .o_mclk_r(o_mclk_r), .o_mclk_m(o_mclk_m),
    .o_mclk_load(o_mclk_load), .o_mclk_pd(o_mclk_pd),
    .o_dot_n(o_dot_n), .o_dot_r(o_dot_r), .o_dot_m(o_dot_m),
    .o_dot_load(o_dot_load), .o_dot_pd(o_dot_pd),
    .o_dot_src(o_dot_src), .o_video_pin_clock_oe(o_video_pin_clock_oe),
    .o_two_mclk_writes(o_two_mclk_writes));

  // 50 MHz clock
  initial i_clk = 1'b0;
  always #10 i_clk = ~i_clk;

  // Random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Model of what a data-port read returns
  function automatic logic [7:0] exp_rd(input logic [7:0] idx);
    if (idx == 8'h08) return regs[8'h08];
    if (regs[8'h08][3:0] == 4'h6 &&
        (idx inside {[8'h10:8'h15], [8'h22:8'h25]})) return regs[idx];
    return 8'h00;
  endfunction : exp_rd

  // Model of the dot dividers for a source select
  function automatic logic [15:0] dot_exp(input logic [1:0] s);
    logic [7:0] l;
    if (s[1]) return {1'b0, regs[8'h12][4:0], regs[8'h12][6:5],
                      1'b0, regs[8'h13][6:0]};
    l = s[0] ? 8'h24 : 8'h22;
    return {regs[l][5:0], regs[l][7:6], regs[l+8'h01]};
  endfunction : dot_exp

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  // One-cycle write strobe, launched and dropped at falling edges
  task automatic io_wr(input logic [1:0] sel, input logic [7:0] d);
    @(negedge i_clk);
    i_io_wr = 1'b1;
    i_io_sel = sel;
    i_io_wdata = d;
    @(negedge i_clk);
    i_io_wr = 1'b0;
  endtask : io_wr

  task automatic seq_wr(input logic [7:0] idx, input logic [7:0] d);
    io_wr(clk_synth_pkg::PORT_SEQ_IDX, idx);
    io_wr(clk_synth_pkg::PORT_SEQ_DAT, d);
    if (idx == 8'h08 || (regs[8'h08][3:0] == 4'h6 &&
        (idx inside {[8'h10:8'h15], [8'h22:8'h25]}))) regs[idx] = d;
  endtask : seq_wr

  // One-cycle read strobe; data taken while valid stands
  task automatic io_rd(input logic [1:0] sel, output logic [7:0] v);
    @(negedge i_clk);
    i_io_rd = 1'b1;
    i_io_sel = sel;
    @(negedge i_clk);
    i_io_rd = 1'b0;
    for (int k = 0; k < 3 && o_io_rvalid !== 1'b1; k++) @(negedge i_clk);
    check("read valid", 32'(o_io_rvalid), 32'h0000_0001);
    v = o_io_rdata;
  endtask : io_rd

  task automatic seq_rd(input logic [7:0] idx, output logic [7:0] v);
    io_wr(clk_synth_pkg::PORT_SEQ_IDX, idx);
    io_rd(clk_synth_pkg::PORT_SEQ_DAT, v);
  endtask : seq_rd

  // Waits a bounded time for one load pulse, then checks dividers
  task automatic load_chk(input logic dot);
    for (int k = 0; k < 5; k++) begin
      @(negedge i_clk);
      if ((dot ? o_dot_load : o_mclk_load) === 1'b1) break;
    end
    check("load pulse", 32'(dot ? o_dot_load : o_mclk_load), 32'h1);
    if (dot) begin
      check("dot div", 32'({o_dot_n, o_dot_r, o_dot_m}),
            32'(dot_exp(misc_sel)));
      check("dot src", 32'(o_dot_src), 32'(misc_sel));
    end else begin
      check("mem div", 32'({o_mclk_n, o_mclk_r, o_mclk_m}),
            32'({regs[8'h10][4:0], regs[8'h10][6:5], regs[8'h11][6:0]}));
    end
  endtask : load_chk

  // Slow edges on one measured clock, then time to settle
  task automatic pulses(input logic dot, input int n);
    repeat (n) begin
      repeat (3) @(negedge i_clk);
      if (dot) i_dot_clk_in = 1'b1;
      else i_mem_clk_in = 1'b1;
      repeat (3) @(negedge i_clk);
      i_dot_clk_in = 1'b0;
      i_mem_clk_in = 1'b0;
    end
    repeat (8) @(negedge i_clk);
  endtask : pulses

  task automatic cnt_chk(input logic [15:0] exp);
    seq_rd(8'h16, hi);
    seq_rd(8'h17, lo);
    check("test count", 32'({hi, lo}), 32'(exp));
  endtask : cnt_chk

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    end_sim();
  end

  // Main sequence
  initial begin
    i_sys_rst = 1'b1;
    i_io_wr = 1'b0;
    i_io_rd = 1'b0;
    i_io_sel = clk_synth_pkg::PORT_NONE;
    i_io_wdata = 8'h00;
    i_mem_clk_in = 1'b0;
    i_dot_clk_in = 1'b0;
    i_video_clock_dir_strap = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    seed = 32'h70ef_b0de;
    misc_sel = 2'h0;
    foreach (regs[i]) regs[i] = 8'h00;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    check("reset div", {o_mclk_n, o_mclk_r, o_mclk_m, o_dot_n, o_dot_r,
                        o_dot_m, o_dot_src}, 32'h0000_0000);
    check("reset ctl", 32'({o_video_pin_clock_oe, o_two_mclk_writes,
                            o_mclk_pd, o_dot_pd}), 32'h0000_0008);
    // Locked range ignores writes; wrong key stays locked
    seq_wr(8'h10, 8'h5A);
    seq_wr(8'h14, 8'h1F);
    repeat (2) @(negedge i_clk);
    check("locked ctl", 32'({o_mclk_pd, o_dot_pd}), 32'h0);
    seq_wr(8'h08, 8'h07);
    seq_wr(8'h11, 8'h3C);
    seq_rd(8'h11, rv);
    check("locked read", 32'(rv), 32'(exp_rd(8'h11)));
    seq_wr(8'h08, 8'hF6);
    // Random divider values, then read back everything
    for (int i = 1; i < 9; i++) begin
      seed = xs(seed);
      seq_wr(idx_list[i], seed[7:0]);
    end
    seq_wr(8'h30, 8'hFF);
    foreach (idx_list[i]) begin
      seq_rd(idx_list[i], rv);
      check("readback", 32'(rv), 32'(exp_rd(idx_list[i])));
    end
    // Strobe load of the memory clock
    seq_wr(8'h15, 8'h01);
    load_chk(1'b0);
    // Every dot source select, each write loads
    for (int s = 0; s < 4; s++) begin
      misc_sel = 2'(s);
      io_wr(clk_synth_pkg::PORT_MISC, {4'h0, misc_sel, 2'h0});
      load_chk(1'b1);
    end
    io_rd(clk_synth_pkg::PORT_MISC, rv);
    check("misc read", 32'(rv), 32'({4'h0, misc_sel, 2'h0}));
    io_rd(clk_synth_pkg::PORT_SEQ_IDX, rv);
    check("index read", 32'(rv), 32'h0000_0015);
    seed = xs(seed);
    seq_wr(8'h12, seed[7:0]);
    seq_wr(8'h15, 8'h02);
    load_chk(1'b1);
    // Immediate mode loads on parameter writes
    seq_wr(8'h15, 8'h20);
    seed = xs(seed);
    seq_wr(8'h10, seed[15:8]);
    load_chk(1'b0);
    seq_wr(8'h13, seed[23:16]);
    load_chk(1'b1);
    seq_wr(8'h15, 8'h00);
    // Power-down bits
    seq_wr(8'h14, 8'h03);
    repeat (2) @(negedge i_clk);
    check("pd", 32'({o_mclk_pd, o_dot_pd}), 32'h3);
    seq_wr(8'h14, 8'h01);
    repeat (2) @(negedge i_clk);
    check("pd", 32'({o_mclk_pd, o_dot_pd}), 32'h1);
    // Test counter: clear, count, select, hold
    seq_wr(8'h14, 8'h14);
    pulses(1'b0, 5);
    cnt_chk(16'h0005);
    pulses(1'b1, 2);
    cnt_chk(16'h0005);
    seq_wr(8'h14, 8'h04);
    pulses(1'b0, 300);
    cnt_chk(16'h0131);
    seq_wr(8'h14, 8'h00);
    pulses(1'b0, 3);
    cnt_chk(16'h0131);
    seq_wr(8'h14, 8'h1C);
    pulses(1'b1, 7);
    pulses(1'b0, 2);
    cnt_chk(16'h0007);
    // Video pin direction and long memory writes
    seq_wr(8'h15, 8'h88);
    repeat (4) @(negedge i_clk);
    check("pin dir", 32'({o_video_pin_clock_oe, o_two_mclk_writes}),
          32'h1);
    i_video_clock_dir_strap = 1'b1;
    repeat (4) @(negedge i_clk);
    check("pin dir", 32'({o_video_pin_clock_oe, o_two_mclk_writes}),
          32'h3);
    i_video_clock_dir_strap = 1'b0;
    seq_wr(8'h15, 8'h00);
    repeat (4) @(negedge i_clk);
    check("pin dir", 32'({o_video_pin_clock_oe, o_two_mclk_writes}),
          32'h2);
    // Relock, write is lost, unlock shows the old value
    seq_wr(8'h08, 8'h00);
    seq_wr(8'h10, 8'h33);
    seq_rd(8'h10, rv);
    check("relocked", 32'(rv), 32'(exp_rd(8'h10)));
    seq_wr(8'h08, 8'h06);
    seq_rd(8'h10, rv);
    check("kept value", 32'(rv), 32'(exp_rd(8'h10)));
    end_sim();
  end
endmodule : pll_clock_synth_control_bench

/* File: verilog/clk_synth_cfg.svh */
// Register offsets, field positions and reset values of the clock
// synthesizer control block. Included by the design files by bare name.
`ifndef CLK_SYNTH_CFG_SVH
`define CLK_SYNTH_CFG_SVH

// Sequencer indices
`define IDX_UNLOCK    8'h08
`define IDX_MCLK_LO   8'h10
`define IDX_MCLK_HI   8'h11
`define IDX_DOT_LO    8'h12
`define IDX_DOT_HI    8'h13
`define IDX_CTL_ONE   8'h14
`define IDX_CTL_TWO   8'h15
`define IDX_TEST_HI   8'h16
`define IDX_TEST_LO   8'h17
`define IDX_ALT_A_LO  8'h22
`define IDX_ALT_A_HI  8'h23
`define IDX_ALT_B_LO  8'h24
`define IDX_ALT_B_HI  8'h25
// Locked extended ranges
`define IDX_EXT_FIRST 8'h09
`define IDX_EXT_LAST  8'h1C
`define IDX_ALT_FIRST 8'h22
`define IDX_ALT_LAST  8'h25

// Unlock key in the low nibble
`define UNLOCK_KEY    4'h6

// Control register one bit positions
`define C1_DOT_PD     0
`define C1_MCLK_PD    1
`define C1_CNT_EN     2
`define C1_CNT_SEL    3
`define C1_CNT_CLR    4
// Control register two bit positions
`define C2_LOAD_MCLK  0
`define C2_LOAD_DOT   1
`define C2_PIN_DIR    3
`define C2_LOAD_IMM   5
`define C2_TWO_MCLK   7
// Miscellaneous output dot clock select field
`define MISC_SEL_HI   3
`define MISC_SEL_LO   2

// Reset values
`define RST_BYTE      8'h00
`define RST_MISC      8'h00

`endif

/* File: verilog/clk_synth_pkg.sv */
// Types shared by the clock synthesizer control files.
// Assumes the constants header is included by each user.
package clk_synth_pkg;

  // Host I/O port select
  typedef enum logic [1:0] {
    PORT_SEQ_IDX = 2'h0,
    PORT_SEQ_DAT = 2'h1,
    PORT_MISC    = 2'h2,
    PORT_NONE    = 2'h3
  } io_port_t;

  // Dot clock parameter source
  typedef enum logic [1:0] {
    SRC_ALT_A = 2'h0,
    SRC_ALT_B = 2'h1,
    SRC_PROG  = 2'h2,
    SRC_PROG2 = 2'h3
  } dot_src_t;

endpackage : clk_synth_pkg

/* File: verilog/pll_clock_synth_control.sv */
// Clock synthesizer control: unlock key, divider parameter registers,
// load strobes and test counter, behind the sequencer index/data port
// and the miscellaneous output port.
// Assumes a host that drives one-cycle read and write strobes on i_clk.
//
// How it works
// - Key 0110 in low nibble unlocks extensions
// - Memory clock N, R, M field layout
// - Dot clock uses the same layout
// - First alternate set: 6-bit N, 8-bit M
// - Second alternate set: same wide layout
// - Control two bit 0 loads memory clock
// - Control two bit 1 loads dot clock
// - Control two bit 5 loads on each parameter write
// - Control one bit 2 enables test counter
// - Control one bit 3 picks measured clock
// - Writing one to bit 4 clears counter
// - Counter read as high and low bytes
// - Control one bits 0,1 power down PLLs
// - Control two bit 3 lets strap set video clock pin direction
// - Control two bit 7 enables long writes
// - Misc output selects and loads dot clock
`timescale 1ns/1ps
`include "clk_synth_cfg.svh"
module pll_clock_synth_control #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // Host I/O port
  input  wire logic       i_io_wr,
  input  wire logic       i_io_rd,
  input  wire logic [1:0] i_io_sel,
  input  wire logic [7:0] i_io_wdata,
  output logic      [7:0] o_io_rdata,
  output logic            o_io_rvalid,
  // Synthesized clocks and strap, asynchronous
  input  wire logic       i_mem_clk_in,
  input  wire logic       i_dot_clk_in,
  input  wire logic       i_video_clock_dir_strap,
  // Memory clock synthesizer
  output logic      [4:0] o_mclk_n,
  output logic      [1:0] o_mclk_r,
  output logic      [6:0] o_mclk_m,
  output logic            o_mclk_load,
  output logic            o_mclk_pd,
  // Dot clock synthesizer
  output logic      [5:0] o_dot_n,
  output logic      [1:0] o_dot_r,
  output logic      [7:0] o_dot_m,
  output logic            o_dot_load,
  output logic            o_dot_pd,
  output logic      [1:0] o_dot_src,
  // Pin and memory controls
  output logic            o_video_pin_clock_oe,
  output logic            o_two_mclk_writes
);

  // Elaboration check on the counter width
  if (CNT_W != 16) begin : g_width_check
    $error("CNT_W must be 16 to fit the two test bytes");
  end

  // Index range test used for both read and write gating
  function automatic logic is_ext(input logic [7:0] idx);
    is_ext = (idx >= `IDX_EXT_FIRST && idx <= `IDX_EXT_LAST) ||
             (idx >= `IDX_ALT_FIRST && idx <= `IDX_ALT_LAST);
  endfunction : is_ext

  // Registers
  logic [7:0] idx_q;
  logic [7:0] key_q;
  logic [7:0] mlo_q;
  logic [7:0] mhi_q;
  logic [7:0] dlo_q;
  logic [7:0] dhi_q;
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic [7:0] alo_q;
  logic [7:0] ahi_q;
  logic [7:0] blo_q;
  logic [7:0] bhi_q;
  logic [7:0] misc_q;
  logic       mload_q;
  logic       dload_q;
  logic [1:0] strap_q;
  logic [7:0] rd_d;

  // Decoded strobes
  wire wr_idx   = i_io_wr && (i_io_sel == clk_synth_pkg::PORT_SEQ_IDX);
  wire wr_dat   = i_io_wr && (i_io_sel == clk_synth_pkg::PORT_SEQ_DAT);
  wire wr_misc  = i_io_wr && (i_io_sel == clk_synth_pkg::PORT_MISC);
  wire unlocked = (key_q[3:0] == `UNLOCK_KEY);
  wire idx_ok   = !is_ext(idx_q) || unlocked;
  wire wr_ok    = wr_dat && idx_ok;
  wire imm      = c2_q[`C2_LOAD_IMM];

  // Per-register write enables
  wire we_key  = wr_ok && (idx_q == `IDX_UNLOCK);
  wire we_mlo  = wr_ok && (idx_q == `IDX_MCLK_LO);
  wire we_mhi  = wr_ok && (idx_q == `IDX_MCLK_HI);
  wire we_dlo  = wr_ok && (idx_q == `IDX_DOT_LO);
  wire we_dhi  = wr_ok && (idx_q == `IDX_DOT_HI);
  wire we_c1   = wr_ok && (idx_q == `IDX_CTL_ONE);
  wire we_c2   = wr_ok && (idx_q == `IDX_CTL_TWO);
  wire we_alo  = wr_ok && (idx_q == `IDX_ALT_A_LO);
  wire we_ahi  = wr_ok && (idx_q == `IDX_ALT_A_HI);
  wire we_blo  = wr_ok && (idx_q == `IDX_ALT_B_LO);
  wire we_bhi  = wr_ok && (idx_q == `IDX_ALT_B_HI);

  // Load requests from strobes, immediate mode and misc output
  wire mload_req = (we_c2 && i_io_wdata[`C2_LOAD_MCLK])
                || (imm && (we_mlo || we_mhi));
  wire dload_req = (we_c2 && i_io_wdata[`C2_LOAD_DOT])
                || (imm && (we_dlo || we_dhi || we_alo ||
                            we_ahi || we_blo || we_bhi))
                || wr_misc;

  // Index and unlock key
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      idx_q <= `RST_BYTE;
      key_q <= `RST_BYTE;
    end else begin
      if (wr_idx) idx_q <= i_io_wdata;
      if (we_key) key_q <= i_io_wdata;
    end
  end

  // Memory and dot clock parameter registers
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mlo_q <= `RST_BYTE;
      mhi_q <= `RST_BYTE;
      dlo_q <= `RST_BYTE;
      dhi_q <= `RST_BYTE;
    end else begin
      if (we_mlo) mlo_q <= i_io_wdata;
      if (we_mhi) mhi_q <= i_io_wdata;
      if (we_dlo) dlo_q <= i_io_wdata;
      if (we_dhi) dhi_q <= i_io_wdata;
    end
  end

  // Alternate dot clock parameter sets
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      alo_q <= `RST_BYTE;
      ahi_q <= `RST_BYTE;
      blo_q <= `RST_BYTE;
      bhi_q <= `RST_BYTE;
    end else begin
      if (we_alo) alo_q <= i_io_wdata;
      if (we_ahi) ahi_q <= i_io_wdata;
      if (we_blo) blo_q <= i_io_wdata;
      if (we_bhi) bhi_q <= i_io_wdata;
    end
  end

  // Control registers and misc output
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      c1_q   <= `RST_BYTE;
      c2_q   <= `RST_BYTE;
      misc_q <= `RST_MISC;
    end else begin
      if (we_c1)   c1_q   <= i_io_wdata;
      if (we_c2)   c2_q   <= i_io_wdata;
      if (wr_misc) misc_q <= i_io_wdata;
    end
  end

  // Load requests wait one cycle so the new bytes are in place
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mload_q <= 1'b0;
      dload_q <= 1'b0;
    end else begin
      mload_q <= mload_req;
      dload_q <= dload_req;
    end
  end

  // Dot clock parameter source from misc output bits 3-2
  wire [1:0] src = misc_q[`MISC_SEL_HI:`MISC_SEL_LO];
  wire       use_a = (src == clk_synth_pkg::SRC_ALT_A);
  wire       use_b = (src == clk_synth_pkg::SRC_ALT_B);
  wire [5:0] sel_n = use_a ? alo_q[5:0]
                   : use_b ? blo_q[5:0]
                   : {1'b0, dlo_q[4:0]};
  wire [1:0] sel_r = use_a ? alo_q[7:6]
                   : use_b ? blo_q[7:6]
                   : dlo_q[6:5];
  wire [7:0] sel_m = use_a ? ahi_q
                   : use_b ? bhi_q
                   : {1'b0, dhi_q[6:0]};

  // Memory clock divider set moves as a whole
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mclk_n    <= 5'h0;
      o_mclk_r    <= 2'h0;
      o_mclk_m    <= 7'h0;
      o_mclk_load <= 1'b0;
    end else begin
      o_mclk_load <= mload_q;
      if (mload_q) begin
        o_mclk_n <= mlo_q[4:0];
        o_mclk_r <= mlo_q[6:5];
        o_mclk_m <= mhi_q[6:0];
      end
    end
  end

  // Dot clock divider set moves as a whole
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dot_n    <= 6'h0;
      o_dot_r    <= 2'h0;
      o_dot_m    <= 8'h0;
      o_dot_load <= 1'b0;
      o_dot_src  <= 2'h0;
    end else begin
      o_dot_load <= dload_q;
      if (dload_q) begin
        o_dot_n   <= sel_n;
        o_dot_r   <= sel_r;
        o_dot_m   <= sel_m;
        o_dot_src <= src;
      end
    end
  end

  // Strap synchroniser and static controls
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      strap_q              <= 2'h0;
      o_mclk_pd            <= 1'b0;
      o_dot_pd             <= 1'b0;
      o_video_pin_clock_oe <= 1'b1;
      o_two_mclk_writes    <= 1'b0;
    end else begin
      strap_q              <= {strap_q[0], i_video_clock_dir_strap};
      o_dot_pd             <= c1_q[`C1_DOT_PD];
      o_mclk_pd            <= c1_q[`C1_MCLK_PD];
      o_video_pin_clock_oe <= c2_q[`C2_PIN_DIR] ? strap_q[1]
                                                 : 1'b1;
      o_two_mclk_writes    <= c2_q[`C2_TWO_MCLK];
    end
  end

  // Test counter control
  test_ctl_if #(.CNT_W(CNT_W)) tc ();
  assign tc.en  = c1_q[`C1_CNT_EN];
  assign tc.sel = c1_q[`C1_CNT_SEL];
  assign tc.clr = we_c1 && i_io_wdata[`C1_CNT_CLR];

  synth_test_counter #(.CNT_W(CNT_W)) u_counter (
    .i_clk        (i_clk),
    .i_sys_rst    (i_sys_rst),
    .i_mem_clk_in (i_mem_clk_in),
    .i_dot_clk_in (i_dot_clk_in),
    .t            (tc.cnt)
  );

  // Read data selection; locked and unmapped read as zero
  always_comb begin
    rd_d = 8'h00;
    unique case (idx_q)
      `IDX_UNLOCK:   rd_d = key_q;
      `IDX_MCLK_LO:  rd_d = mlo_q;
      `IDX_MCLK_HI:  rd_d = mhi_q;
      `IDX_DOT_LO:   rd_d = dlo_q;
      `IDX_DOT_HI:   rd_d = dhi_q;
      `IDX_CTL_ONE:  rd_d = c1_q;
      `IDX_CTL_TWO:  rd_d = c2_q;
      `IDX_TEST_HI:  rd_d = tc.count[15:8];
      `IDX_TEST_LO:  rd_d = tc.count[7:0];
      `IDX_ALT_A_LO: rd_d = alo_q;
      `IDX_ALT_A_HI: rd_d = ahi_q;
      `IDX_ALT_B_LO: rd_d = blo_q;
      `IDX_ALT_B_HI: rd_d = bhi_q;
      default:       rd_d = 8'h00;
    endcase
  end

  wire [7:0] rd_mux =
    (i_io_sel == clk_synth_pkg::PORT_SEQ_IDX) ? idx_q :
    (i_io_sel == clk_synth_pkg::PORT_MISC)    ? misc_q :
    (i_io_sel == clk_synth_pkg::PORT_SEQ_DAT && idx_ok) ? rd_d
                                                        : 8'h00;

  // Registered read answer
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_io_rdata  <= 8'h00;
      o_io_rvalid <= 1'b0;
    end else begin
      o_io_rvalid <= i_io_rd;
      if (i_io_rd) o_io_rdata <= rd_mux;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_write_c2(int b);
    we_c2 && i_io_wdata[b];
  endsequence

  a_unlock_key: assert property (
    wr_dat && idx_q == `IDX_UNLOCK && i_io_wdata[3:0] == 4'h6
    |=> unlocked)
    else $error("key pattern did not unlock");
  a_locked_write: assert property (
    wr_dat && !unlocked && idx_q == `IDX_CTL_ONE |=> $stable(c1_q))
    else $error("locked register was written");
  a_mclk_load: assert property (
    s_write_c2(0) |=> ##1 o_mclk_load && o_mclk_m == mhi_q[6:0])
    else $error("memory clock load missing");
  a_dot_load: assert property (
    s_write_c2(1) |=> ##1 o_dot_load)
    else $error("dot clock load missing");
  a_imm_load: assert property (
    imm && we_mlo |-> ##2 o_mclk_load && o_mclk_n == $past(i_io_wdata[4:0], 2))
    else $error("immediate load missing");
  a_test_read: assert property (
    i_io_rd && i_io_sel == clk_synth_pkg::PORT_SEQ_DAT && unlocked &&
    idx_q == `IDX_TEST_LO |=> o_io_rdata == $past(tc.count[7:0]))
    else $error("test low byte wrong");
  a_mclk_stable: assert property (
    !mload_q |=> $stable(o_mclk_m) && $stable(o_mclk_n) && $stable(o_mclk_r))
    else $error("memory dividers changed without load");
  a_pd_follow: assert property (
    we_c1 |=> ##1 o_dot_pd == $past(i_io_wdata[0], 2))
    else $error("dot clock power down not applied");

endmodule : pll_clock_synth_control

/* File: verilog/synth_test_counter.sv */
// Edge counter that measures the selected synthesized clock.
// Assumes both measured clocks are below half of i_clk.
`timescale 1ns/1ps
`include "clk_synth_cfg.svh"
module synth_test_counter #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // Measured clocks, asynchronous to i_clk
  input  wire logic i_mem_clk_in,
  input  wire logic i_dot_clk_in,
  // Control and result
  test_ctl_if.cnt   t
);

  logic [2:0]       mem_sync_q;
  logic [2:0]       dot_sync_q;
  logic             edge_seen;
  logic [CNT_W-1:0] count_q;

  // Two-flop synchronisers plus an edge history flop
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mem_sync_q <= 3'h0;
      dot_sync_q <= 3'h0;
    end else begin
      mem_sync_q <= {mem_sync_q[1:0], i_mem_clk_in};
      dot_sync_q <= {dot_sync_q[1:0], i_dot_clk_in};
    end
  end

  // Rising edge of the chosen clock, second and third stage only
  assign edge_seen = t.sel ? (dot_sync_q[1] & ~dot_sync_q[2])
                           : (mem_sync_q[1] & ~mem_sync_q[2]);

  // Clear wins, then counting only while enabled
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_q <= '0;
    end else if (t.clr) begin
      count_q <= '0;
    end else if (t.en && edge_seen) begin
      count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign t.count = count_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_count_hold: assert property (!t.en && !t.clr |=> $stable(count_q))
    else $error("test counter moved while disabled");
  a_count_clear: assert property (t.clr |=> count_q == '0)
    else $error("test counter not cleared");

endmodule : synth_test_counter

/* File: verilog/test_ctl_if.sv */
// Control and result bundle between the register file and the
// synthesizer test counter. Both ends run on i_clk.
`timescale 1ns/1ps
interface test_ctl_if #(parameter int CNT_W = 16);
  logic             en;
  logic             sel;
  logic             clr;
  logic [CNT_W-1:0] count;

  modport ctrl (output en, output sel, output clr, input count);
  modport cnt  (input en, input sel, input clr, output count);
endinterface : test_ctl_if
